// >>> verilog/twl_pkg.sv
package twl_pkg;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned PROG_TIME_MS = 10;
  localparam int unsigned PROG_CYC     = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned PROG_W       = 20;

  // ---------------------------------------------------------------------------
  // Memory shape and control byte
  // ---------------------------------------------------------------------------
  localparam int unsigned ROWS         = 32;
  localparam int unsigned ROW_W        = 5;
  localparam int unsigned WORD_W       = 16;
  localparam logic [3:0]  LAST_BIT     = 4'h7;
  localparam logic [1:0]  MODE_LO_INC  = 2'h1;
  localparam logic [1:0]  MODE_HI_DEC  = 2'h2;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  REG_STATUS   = 4'h0;
  localparam logic [3:0]  REG_CTRL     = 4'h4;
  localparam int unsigned ST_STANDBY   = 0;
  localparam int unsigned ST_BUSY      = 1;
  localparam int unsigned ST_DIR       = 2;
  localparam int unsigned ST_ROW_LSB   = 8;
  localparam int unsigned CTRL_EN      = 0;
  localparam logic        CTRL_EN_RST  = 1'b1;

  typedef enum logic [2:0] {
    TWL_IDLE, TWL_CTRL_RX, TWL_ACK, TWL_WR_RX, TWL_RD_TX, TWL_RD_ACK, TWL_IGNORE
  } twl_state_t;
endpackage

// >>> verilog/twl_slave.sv
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
// Functional notes
// - Data falling while clock high is a START.
// - Data rising while clock high is a STOP.
// - START wakes device from standby; STOP returns it to standby.
// - Receiver acknowledges each byte by holding data low one extra pulse.
// - Transmitter stops sending and returns to receive when no acknowledge.
// - In standby the data line is released as input.
// - First byte: five-bit row, two order-mode bits, direction bit.
// - Direction bit zero means write, one means read.
// - Storage holds 32 rows of 16-bit words.
// - Device times its own programming cycle internally.
// - Control byte not acknowledged during programming; master polls.
// - Mode 01 low first increment; 10 high first decrement; 00 high first.
// - Sequential reads step row after two bytes, reloading, wrapping around.
// - Whole addressed word loaded into buffer, read or overwritten bytewise.
module twl_slave
  import twl_pkg::*;
#(
  parameter logic [PROG_W-1:0] PROG_CYCLES = PROG_W'(PROG_CYC)
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  input  wire logic        LINK_CLOCK_PAD_I,
  input  wire logic        LINK_DATA_PAD_I,
  output logic             LINK_DATA_PAD_O,
  output logic             LINK_DATA_PAD_OE_O,
  output logic             STANDBY_O,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                 scl_s;    // [0] first sync stage, [1] second
    logic [1:0]                 sda_s;
    logic                       scl_q;
    logic                       sda_q;
    twl_state_t                 st;
    logic [3:0]                 bits;
    logic [7:0]                 sh;
    logic                       ph;
    logic [ROW_W-1:0]           row;
    logic                       hi_first;
    logic                       step_dn;
    logic                       rd_dir;
    logic                       byte_idx;
    logic                       dirty;
    logic [WORD_W-1:0]          buffer;
    logic [ROWS-1:0][WORD_W-1:0] mem;
    logic [PROG_W-1:0]          prog_cnt;
    logic                       drive_low;
    logic                       en;
    logic [31:0]                rdata;
    logic                       rvalid;
  } twl_regs_t;

  twl_regs_t r;
  twl_regs_t next_r;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy;

  // ---------------------------------------------------------------------------
  // Line events, taken only from the second sync stage
  // ---------------------------------------------------------------------------
  assign scl       = r.scl_s[1];
  assign sda       = r.sda_s[1];
  assign scl_rise  = scl & ~r.scl_q;
  assign scl_fall  = ~scl & r.scl_q;
  assign start_det = scl & r.scl_q & r.sda_q & ~sda;
  assign stop_det  = scl & r.scl_q & ~r.sda_q & sda;
  assign busy      = (r.prog_cnt != '0);

  // Byte of the buffer that goes next: first byte is high when hi_first
  function automatic logic [7:0] pick(input logic [WORD_W-1:0] w, input logic hi);
    pick = hi ? w[15:8] : w[7:0];
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    next_r   = r;
    rx_byte  = {r.sh[6:0], sda};
    tx_byte  = pick(r.buffer, r.hi_first ^ r.byte_idx);
    next_r.scl_s = {r.scl_s[0], LINK_CLOCK_PAD_I};
    next_r.sda_s = {r.sda_s[0], LINK_DATA_PAD_I};
    next_r.scl_q = scl;
    next_r.sda_q = sda;

    // Programming runs on its own clock count, master gives no timing
    if (busy) begin
      next_r.prog_cnt = r.prog_cnt - 1'b1;
    end

    // Link protocol; START and STOP win over bit events
    if (!r.en) begin
      next_r.st        = TWL_IDLE;
      next_r.drive_low = 1'b0;
    end else if (start_det) begin
      next_r.st        = TWL_CTRL_RX;
      next_r.bits      = '0;
      next_r.drive_low = 1'b0;
    end else if (stop_det) begin
      // A completed write is committed at STOP, then the cell is busy
      if (r.st != TWL_IDLE && !r.rd_dir && r.dirty && !busy) begin
        next_r.mem[r.row] = r.buffer;
        next_r.prog_cnt   = PROG_CYCLES;
      end
      next_r.dirty     = 1'b0;
      next_r.st        = TWL_IDLE;
      next_r.drive_low = 1'b0;
    end else begin
      unique case (r.st)
        TWL_IDLE, TWL_IGNORE: begin
          next_r.drive_low = 1'b0;
        end
        TWL_CTRL_RX: begin
          if (scl_rise) begin
            next_r.sh   = rx_byte;
            next_r.bits = r.bits + 1'b1;
            if (r.bits == LAST_BIT) begin
              next_r.row      = rx_byte[7:3];
              next_r.hi_first = (rx_byte[2:1] != MODE_LO_INC);
              next_r.step_dn  = (rx_byte[2:1] == MODE_HI_DEC);
              next_r.rd_dir   = rx_byte[0];
              next_r.buffer   = r.mem[rx_byte[7:3]];
              next_r.byte_idx = 1'b0;
              next_r.dirty    = 1'b0;
              next_r.ph       = 1'b0;
              // While programming the control byte goes unanswered
              next_r.st       = busy ? TWL_IGNORE : TWL_ACK;
            end
          end
        end
        TWL_ACK: begin
          if (scl_fall && !r.ph) begin
            next_r.drive_low = 1'b1;
            next_r.ph        = 1'b1;
          end else if (scl_fall) begin
            next_r.ph   = 1'b0;
            next_r.bits = '0;
            if (r.rd_dir) begin
              // First data bit goes out on the same falling edge
              next_r.sh        = tx_byte;
              next_r.drive_low = ~tx_byte[7];
              next_r.st        = TWL_RD_TX;
            end else begin
              next_r.drive_low = 1'b0;
              next_r.st        = TWL_WR_RX;
            end
          end
        end
        TWL_WR_RX: begin
          if (scl_rise) begin
            next_r.sh   = rx_byte;
            next_r.bits = r.bits + 1'b1;
            if (r.bits == LAST_BIT) begin
              // Overwrite one half of the buffer; extra bytes keep alternating
              if (r.hi_first ^ r.byte_idx) begin
                next_r.buffer[15:8] = rx_byte;
              end else begin
                next_r.buffer[7:0] = rx_byte;
              end
              next_r.byte_idx = ~r.byte_idx;
              next_r.dirty    = 1'b1;
              next_r.ph       = 1'b0;
              next_r.st       = TWL_ACK;
            end
          end
        end
        TWL_RD_TX: begin
          if (scl_fall) begin
            if (r.bits == LAST_BIT) begin
              next_r.drive_low = 1'b0;  // Let the master acknowledge
              next_r.ph        = 1'b0;
              next_r.st        = TWL_RD_ACK;
            end else begin
              next_r.sh        = {r.sh[6:0], 1'b0};
              next_r.drive_low = ~r.sh[6];
              next_r.bits      = r.bits + 1'b1;
            end
          end
        end
        TWL_RD_ACK: begin
          if (scl_rise) begin
            if (sda) begin
              next_r.st = TWL_IGNORE;
            end else begin
              next_r.ph       = 1'b1;
              next_r.byte_idx = ~r.byte_idx;
              if (r.byte_idx) begin
                // Both halves sent: step the row, wrap is natural overflow
                next_r.row    = r.step_dn ? r.row - 1'b1 : r.row + 1'b1;
                next_r.buffer = r.mem[r.step_dn ? r.row - 1'b1 : r.row + 1'b1];
              end
            end
          end else if (scl_fall && r.ph) begin
            next_r.ph        = 1'b0;
            next_r.bits      = '0;
            next_r.sh        = tx_byte;
            next_r.drive_low = ~tx_byte[7];
            next_r.st        = TWL_RD_TX;
          end
        end
      endcase
    end

    // Bus slave: reads wait one cycle for registered data, writes take no wait
    next_r.rvalid = AVS_READ_I & ~r.rvalid;
    next_r.rdata  = '0;
    if (AVS_READ_I && !r.rvalid) begin
      if (AVS_ADDRESS_I == REG_STATUS) begin
        next_r.rdata[ST_STANDBY] = (r.st == TWL_IDLE);
        next_r.rdata[ST_BUSY]    = busy;
        next_r.rdata[ST_DIR]     = r.rd_dir;
        next_r.rdata[ST_ROW_LSB +: ROW_W] = r.row;
      end else if (AVS_ADDRESS_I == REG_CTRL) begin
        next_r.rdata[CTRL_EN] = r.en;
      end
    end
    if (AVS_WRITE_I && AVS_ADDRESS_I == REG_CTRL && AVS_BYTEENABLE_I[0]) begin
      next_r.en = AVS_WRITEDATA_I[CTRL_EN];
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      r       <= '0;
      r.scl_s <= 2'h3;  // Idle lines are pulled high
      r.sda_s <= 2'h3;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.st    <= TWL_IDLE;
      r.en    <= CTRL_EN_RST;
    end else begin
      r <= next_r;
    end
  end

  // Open-drain pad: only ever pulls low
  assign LINK_DATA_PAD_O    = 1'b0;
  assign LINK_DATA_PAD_OE_O = r.drive_low;
  assign STANDBY_O          = (r.st == TWL_IDLE);
  assign AVS_READDATA_O     = r.rdata;
  assign AVS_WAITREQUEST_O  = AVS_READ_I & ~r.rvalid;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_start_wakes: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (start_det && r.en) |=> (r.st == TWL_CTRL_RX && r.bits == '0))
    else $error("START did not open control byte reception");

  a_stop_sleeps: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (stop_det && !start_det) |=> (r.st == TWL_IDLE && STANDBY_O))
    else $error("STOP did not return to standby");

  a_standby_released: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.st == TWL_IDLE) |-> !LINK_DATA_PAD_OE_O)
    else $error("Data pad driven in standby");

  a_busy_no_ack: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.en && !start_det && !stop_det && r.st == TWL_CTRL_RX && scl_rise
     && r.bits == LAST_BIT && busy) |=> (r.st == TWL_IGNORE) ##1 !LINK_DATA_PAD_OE_O)
    else $error("Control byte acknowledged while programming");

  a_nack_stops_tx: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.en && !start_det && !stop_det && r.st == TWL_RD_ACK && scl_rise && sda)
    |=> (r.st == TWL_IGNORE && !LINK_DATA_PAD_OE_O) ##1 !LINK_DATA_PAD_OE_O)
    else $error("Transmission continued after no acknowledge");

  a_ctrl_decode: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.en && !start_det && !stop_det && r.st == TWL_CTRL_RX && scl_rise
     && r.bits == LAST_BIT)
    |=> (r.row == $past(r.sh[6:2]) && r.rd_dir == $past(sda)))
    else $error("Control byte decoded wrongly");

  a_prog_timed: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.en && stop_det && !start_det && r.st != TWL_IDLE && !r.rd_dir && r.dirty && !busy)
    |=> (r.prog_cnt == PROG_CYCLES) ##1 (r.prog_cnt == PROG_CYCLES - 1'b1))
    else $error("Programming count not started from its full value");

  a_ack_drives: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.en && !start_det && !stop_det && r.st == TWL_ACK && !r.ph && scl_fall)
    |=> LINK_DATA_PAD_OE_O)
    else $error("Acknowledge not driven after a byte");

  a_ack_released: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.en && !start_det && !stop_det && r.st == TWL_ACK && r.ph && scl_fall && !r.rd_dir)
    |=> !LINK_DATA_PAD_OE_O)
    else $error("Acknowledge held past its clock pulse");

  a_tx_msb_first: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.en && !start_det && !stop_det && r.st == TWL_RD_TX && scl_fall && r.bits != LAST_BIT)
    |=> (LINK_DATA_PAD_OE_O == !$past(r.sh[6])))
    else $error("Read bit not shifted out most significant first");

  a_row_step: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.en && !start_det && !stop_det && r.st == TWL_RD_ACK && scl_rise && !sda && r.byte_idx)
    |=> (r.row == (r.step_dn ? $past(r.row) - 1'b1 : $past(r.row) + 1'b1)))
    else $error("Row not stepped after both bytes");

  a_write_commit: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (r.en && stop_det && !start_det && r.st != TWL_IDLE && !r.rd_dir && r.dirty && !busy)
    |=> (r.mem[r.row] == $past(r.buffer)))
    else $error("Written word not committed at STOP");

  a_enable_off: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    !r.en
    |=> (STANDBY_O && !LINK_DATA_PAD_OE_O))
    else $error("Disabled link left standby");

  a_read_waits: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (AVS_READ_I && !r.rvalid) |-> AVS_WAITREQUEST_O ##1 (r.rvalid && !AVS_WAITREQUEST_O))
    else $error("Read answered without one wait cycle");

endmodule // twl_slave

// >>> sim/twl_link_master.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Link master model: 80 ns bit period, 5 clocks low and 3 clocks high
// ---------------------------------------------------------------------------
module twl_link_master (
  input  wire logic clk_i,
  input  wire logic dut_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic drive_low;  // Master pulls the data wire low

  // Open-drain wire with pull-up; either party may pull it low
  assign sda_o = ~(drive_low | dut_oe_i);

  // Clock and data idle high; the master alone makes the clock
  initial begin
    scl_o = 1'b1;
    drive_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Data falls while the clock is high; also serves as repeated start
  task automatic start();
    drive_low <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    drive_low <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(3);
  endtask

  // Data rises while the clock is high
  task automatic stop();
    tick(2);
    drive_low <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    drive_low <= 1'b0;
    tick(6);
  endtask

  // Eight bits MSB first plus the ninth pulse; data moves mid-low only,
  // late enough for the device to release its previous drive
  task automatic byte_slot(input logic [7:0] tx, input logic ninth,
                           output logic [7:0] rx, output logic ninth_low);
    logic [8:0] bits;
    bits = {tx, ninth};
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      drive_low <= ~bits[i];
      tick(3);
      scl_o <= 1'b1;
      tick(3);
      if (i > 0) rx[i-1] = sda_o;
      else ninth_low = ~sda_o;
      scl_o <= 1'b0;
    end
    tick(1);
    drive_low <= 1'b0;
  endtask
endmodule  // twl_link_master

// >>> sim/test_two_wire_eeprom_slave_link.sv
`timescale 1ns/1ps
`define TWL_CHECK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module test_two_wire_eeprom_slave_link;
  import twl_pkg::*;
  logic        clock, resetn, scl, sda, oe, standby, rd, wr, waitreq, pad;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata, d;
  logic [7:0]  g;
  logic        ak;
  int          mismatches, n_compared;

  // ---------------------------------------------------------------------------
  // Design, link master and clock
  // ---------------------------------------------------------------------------
  twl_slave #(.PROG_CYCLES(20'h0_00C8)) u_dut (
    .CLOCK_I(clock), .RESETN_I(resetn), .LINK_CLOCK_PAD_I(scl),
    .LINK_DATA_PAD_I(sda), .LINK_DATA_PAD_O(pad), .LINK_DATA_PAD_OE_O(oe),
    .STANDBY_O(standby), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq));
  twl_link_master u_master (.clk_i(clock), .dut_oe_i(oe), .scl_o(scl), .sda_o(sda));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------------------------------------
  // Bus tasks: hold the request until waitrequest is seen low at an edge
  // ---------------------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v,
                     output logic [31:0] r);
    addr <= a;
    wdata <= v;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    // Waitrequest and read data are taken at the same rising edge
    @(posedge clock);
    while (waitreq !== 1'b0) @(posedge clock);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // One idle edge keeps back-to-back calls from re-raising in one step
    @(posedge clock);
  endtask

  // Write one row of two bytes, then poll until programming ends
  task automatic wr_row(input logic [7:0] c, input logic [7:0] b1, input logic [7:0] b2);
    u_master.start();
    `TWL_CHECK(standby, 1'b0)
    u_master.byte_slot(c, 1'b1, g, ak);
    `TWL_CHECK(ak, 1'b1)
    u_master.byte_slot(b1, 1'b1, g, ak);
    `TWL_CHECK(ak, 1'b1)
    u_master.byte_slot(b2, 1'b1, g, ak);
    `TWL_CHECK(ak, 1'b1)
    u_master.stop();
    `TWL_CHECK(standby, 1'b1)
    bus(1'b0, REG_STATUS, 32'h0, d);
    `TWL_CHECK(d[2:0], 3'h3)
    // Polling while busy must be refused
    u_master.start();
    u_master.byte_slot(c, 1'b1, g, ak);
    `TWL_CHECK(ak, 1'b0)
    u_master.stop();
    for (int i = 0; i < 60 && d[ST_BUSY] !== 1'b0; i++) bus(1'b0, REG_STATUS, 32'h0, d);
    `TWL_CHECK(d[ST_BUSY], 1'b0)
  endtask

  // Read four bytes, acknowledging all but the last
  task automatic rd_seq(input logic [7:0] c, input logic [31:0] exp);
    u_master.start();
    u_master.byte_slot(c, 1'b1, g, ak);
    `TWL_CHECK(ak, 1'b1)
    for (int i = 3; i >= 0; i--) begin
      u_master.byte_slot(8'hFF, (i == 0), g, ak);
      `TWL_CHECK(g, exp[i*8 +: 8])
    end
    u_master.tick(6);
    `TWL_CHECK(oe, 1'b0)
    u_master.stop();
    bus(1'b0, REG_STATUS, 32'h0, d);
    `TWL_CHECK(d[2:0], 3'h5)
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {rd, wr, addr, wdata} = '0;
    be = 4'hF;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    // Reset state and register map, unmapped address included
    `TWL_CHECK({standby, oe}, 2'h2)
    `TWL_CHECK(pad, 1'b0)
    bus(1'b0, REG_CTRL, 32'h0, d);
    `TWL_CHECK(d, 32'h0000_0001)
    bus(1'b0, 4'h8, 32'h0, d);
    `TWL_CHECK(d, 32'h0000_0000)
    // A control write without its byte enable is ignored
    be <= 4'h0;
    bus(1'b1, REG_CTRL, 32'h0, d);
    be <= 4'hF;
    bus(1'b0, REG_CTRL, 32'h0, d);
    `TWL_CHECK(d, 32'h0000_0001)
    $display("reset test done");
    // Row 5 high byte first, row 0 low byte first
    wr_row(8'h28, 8'hA5, 8'h3C);
    wr_row(8'h02, 8'h11, 8'h22);
    $display("write test done");
    // Decrement from row 5 into empty row 4; increment from row 31 wraps to 0
    rd_seq(8'h2D, 32'hA53C_0000);
    rd_seq(8'hFB, 32'h0000_1122);
    // Modes 00 and 11 on reads: high byte first, row increments
    rd_seq(8'hF9, 32'h0000_2211);
    rd_seq(8'h07, 32'h2211_0000);
    $display("read test done");
    // Link disabled: control byte ignored, device stays in standby
    bus(1'b1, REG_CTRL, 32'h0, d);
    u_master.start();
    u_master.byte_slot(8'h29, 1'b1, g, ak);
    `TWL_CHECK({ak, standby}, 2'h1)
    u_master.stop();
    bus(1'b1, REG_CTRL, 32'h1, d);
    rd_seq(8'h2D, 32'hA53C_0000);
    $display("enable test done");
    tally_and_finish();
  end
endmodule  // test_two_wire_eeprom_slave_link
